// ### rtl/spiq_defs.svh
// Purpose: shared constants of the queued spi block
// Assumes: included by bare name wherever a constant is needed
// Notes: definitions only
`ifndef SPIQ_DEFS_SVH
`define SPIQ_DEFS_SVH

// ****************************************
// bit clock divider, last count of a half bit
// ****************************************
`define SPIQ_HALF_DIV2 7'h00
`define SPIQ_HALF_DIV8 7'h03
`define SPIQ_HALF_DIV32 7'h0f
`define SPIQ_HALF_DIVIDE_BY_128 7'h3f

// ****************************************
// framing
// ****************************************
`define SPIQ_LAST_BIT 3'h7
`define SPIQ_BIT1_CAPTURE 3'h6
`define SPIQ_SHIFT_RESET 8'h00
`define SPIQ_CAP_DELAY 2

`endif

// ### rtl/spiq_pkg.sv
// Purpose: types of the queued spi block
// Assumes: nothing beyond the constants header
// Notes: master state codes are gray along idle, armed, shift
package spiq_pkg;

	typedef logic [7:0] spiq_byte_t;

	typedef enum logic [1:0] {
		SPIQ_IDLE = 2'h0,
		SPIQ_ARMED = 2'h1,
		SPIQ_SHIFT = 2'h3
	} spiq_state_t;

	// ascending divide order by code
	typedef enum logic [1:0] {
		SPIQ_DIV2 = 2'h0,
		SPIQ_DIV8 = 2'h1,
		SPIQ_DIV32 = 2'h2,
		SPIQ_DIVIDE_BY_128 = 2'h3
	} spiq_rate_t;

endpackage : spiq_pkg

// ### rtl/spiq_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: din is asynchronous to clk
// Notes: only the second stage is visible
module spiq_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic meta_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			dout <= RESET_VAL;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule : spiq_sync

// ### rtl/spiq_link.sv
// Purpose: slave shift engine running on the incoming serial clock
// Assumes: clock_phase 1 format; polarity static while enabled
// Notes: events leave as toggles, data words are held for a whole byte
module spiq_link
	import spiq_pkg::*;
(
	input wire logic link_sck,
	input wire logic clock_polarity,
	input wire logic slave_on,
	input wire logic ss_n_in,
	input wire logic mosi_in,
	input wire spiq_pkg::spiq_byte_t tx_byte,
	output logic miso_out,
	output logic miso_oe_n,
	output logic start_tgl,
	output logic bit1_tgl,
	output logic done_tgl,
	output spiq_pkg::spiq_byte_t rx_byte
);
	import spiq_pkg::*;
	`include "spiq_defs.svh"

	logic [2:0] cnt_reg;
	spiq_byte_t out_reg;
	logic [6:0] in_reg;

	// leading edge is the rising edge of this wire in both polarities
	wire lead_clk = link_sck ^ clock_polarity;
	// slave select high ends the frame at once; the clock may stop
	wire abort = ss_n_in | ~slave_on;
	wire first_edge = (cnt_reg == 3'h0);

	// ****************************************
	// leading edge: drive miso
	// ****************************************
	always_ff @(posedge lead_clk or posedge abort) begin
		if (abort) begin
			miso_oe_n <= 1'b1;
			miso_out <= 1'b0;
			out_reg <= `SPIQ_SHIFT_RESET;
		end else if (first_edge) begin
			miso_oe_n <= 1'b0;
			miso_out <= tx_byte[7];
			out_reg <= {tx_byte[6:0], 1'b0};
		end else begin
			miso_out <= out_reg[7];
			out_reg <= {out_reg[6:0], 1'b0};
		end
	end

	// start_tgl flips at the start edge of a frame, the only edge where tx_byte is sampled above
	always_ff @(posedge lead_clk or negedge slave_on) begin
		if (!slave_on)
			start_tgl <= 1'b0;
		else if (first_edge && !ss_n_in)
			start_tgl <= ~start_tgl;
	end

	// ****************************************
	// trailing edge: capture mosi
	// ****************************************
	always_ff @(negedge lead_clk or posedge abort) begin
		if (abort) begin
			cnt_reg <= 3'h0;
			in_reg <= 7'h00;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
			in_reg <= {in_reg[5:0], mosi_in};
		end
	end

	always_ff @(negedge lead_clk or negedge slave_on) begin
		if (!slave_on) begin
			bit1_tgl <= 1'b0;
			done_tgl <= 1'b0;
			rx_byte <= `SPIQ_SHIFT_RESET;
		end else if (!ss_n_in) begin
			if (cnt_reg == `SPIQ_BIT1_CAPTURE)
				bit1_tgl <= ~bit1_tgl;
			if (cnt_reg == `SPIQ_LAST_BIT) begin
				done_tgl <= ~done_tgl;
				rx_byte <= {in_reg, mosi_in};
			end
		end
	end
endmodule : spiq_link

// ### rtl/spiq_top.sv
// Purpose: queued spi with phase 1 format, start latency and overflow
// Assumes: software strobes come from mclk logic, one cycle each
// Notes: pins go through two flops; the slave engine runs on link_sck
//
// Summary of operation
// - slave drives miso only while slave select is low.
// - phase 1 master drives mosi on first edge; slave starts there.
// - phase 1 slave select may stay low across back-to-back bytes.
// - slave leaves idle on first edge, driving its transmit msb.
// - slave shift register is never reloaded during a transfer.
// - master data write starts a transfer; phase does not delay it.
// - phase 0 clock idle first half bit; phase 1 starts with edge.
// - master bit clock free-runs only with enable and master select.
// - write to transfer start is at most one bit time.
// - double buffered transmit; queued master byte follows at once.
// - without a new write, the old shift contents go out again.
// - idle side sets empty flag within two cycles of buffer load.
// - busy slave keeps the buffer, empty flag clear until the end.
// - overflow set if unread data at bit 1 capture strobe.
// - during overflow no byte reaches receive data; old byte stays.
// - overflow cleared by status read then data read.
// - error enable routes overflow onto the shared receive request.
// - one enable for both errors; fault enable low blocks fault flag.
// - fault flag set when slave select conflicts with mode.
// - any data write clears the empty flag.
// - full flag cleared by status read while set, then data read.
module spiq_top
	import spiq_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic link_sck,
	input wire logic spi_enable,
	input wire logic master_select,
	input wire logic clock_phase,
	input wire logic clock_polarity,
	input wire spiq_pkg::spiq_rate_t rate_select,
	input wire logic mode_fault_enable,
	input wire logic error_irq_enable,
	input wire logic rx_irq_enable,
	input wire logic data_write,
	input wire spiq_pkg::spiq_byte_t write_data,
	input wire logic status_read,
	input wire logic data_read,
	input wire logic control_write,
	input wire logic ss_n_in,
	input wire logic mosi_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic sck_oe_n,
	output logic mosi_out,
	output logic mosi_oe_n,
	output logic miso_out,
	output logic miso_oe_n,
	output logic tx_empty_flag,
	output logic rx_full_flag,
	output logic overflow_flag,
	output logic mode_fault_flag,
	output spiq_pkg::spiq_byte_t rx_data,
	output logic rx_err_irq
);
	import spiq_pkg::*;
	`include "spiq_defs.svh"

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [6:0] spiq_edge_at(input spiq_rate_t rate,
			input logic second_half);
		logic [6:0] half;
		half = `SPIQ_HALF_DIV2;
		case (rate)
			SPIQ_DIV2: half = `SPIQ_HALF_DIV2;
			SPIQ_DIV8: half = `SPIQ_HALF_DIV8;
			SPIQ_DIV32: half = `SPIQ_HALF_DIV32;
			SPIQ_DIVIDE_BY_128: half = `SPIQ_HALF_DIVIDE_BY_128;
			default: half = `SPIQ_HALF_DIV2;
		endcase
		return second_half ? {half[5:0], 1'b1} : half;
	endfunction : spiq_edge_at

	// ****************************************
	// state
	// ****************************************
	spiq_state_t state_reg, state_next;
	logic [6:0] div_reg;
	logic [2:0] bit_reg, bit_next;
	logic act_reg, act_next;
	logic mosi_next;
	spiq_byte_t shift_reg, tx_buf_reg;
	logic tx_full_reg;
	logic [1:0] cap_reg;
	logic [6:0] mrx_reg;
	logic [2:0] mrx_cnt_reg;
	logic sl_busy_reg, slave_on_reg, mf_lock_reg;
	logic start_q_reg, bit1_q_reg, done_q_reg;
	logic rxf_arm_reg, ovf_arm_reg, mode_fault_flag_arm_reg;

	logic ss_s, miso_s, start_s, bit1_s, done_s;
	logic start_t, bit1_t, done_t;
	spiq_byte_t sl_rx;

	// ****************************************
	// pin and crossing synchronisers
	// ****************************************
	// ss resets high so a master is not faulted by the reset value
	spiq_sync #(.RESET_VAL(1'b1)) u_ss (
		.clk(mclk), .rst(rst), .din(ss_n_in), .dout(ss_s));
	spiq_sync u_miso (
		.clk(mclk), .rst(rst), .din(miso_in), .dout(miso_s));
	spiq_sync u_start (
		.clk(mclk), .rst(rst), .din(start_t), .dout(start_s));
	spiq_sync u_bit1 (
		.clk(mclk), .rst(rst), .din(bit1_t), .dout(bit1_s));
	spiq_sync u_done (
		.clk(mclk), .rst(rst), .din(done_t), .dout(done_s));

	spiq_link u_link (
		.link_sck(link_sck),
		.clock_polarity(clock_polarity),
		.slave_on(slave_on_reg),
		.ss_n_in(ss_n_in),
		.mosi_in(mosi_in),
		.tx_byte(shift_reg),
		.miso_out(miso_out),
		.miso_oe_n(miso_oe_n),
		.start_tgl(start_t),
		.bit1_tgl(bit1_t),
		.done_tgl(done_t),
		.rx_byte(sl_rx)
	);

	// ****************************************
	// mode decode and bit clock
	// ****************************************
	wire run_en = spi_enable & ~mf_lock_reg;
	wire m_run = run_en & master_select;
	wire s_run = run_en & ~master_select;
	wire tick_mid = m_run & (div_reg == spiq_edge_at(rate_select, 1'b0));
	wire tick_end = m_run & (div_reg == spiq_edge_at(rate_select, 1'b1));
	// divider stops, and resets, outside master operation to save power
	wire [6:0] div_next = (!m_run || tick_end) ? 7'h00 :
		div_reg + 7'h01;

	wire in_shift = (state_reg == SPIQ_SHIFT);
	wire last_bit = (bit_reg == `SPIQ_LAST_BIT);
	wire byte_end = in_shift & tick_end & last_bit;
	// queued byte is taken at the end of the last bit, no gap
	wire take_m = m_run & tx_full_reg &
		((state_reg == SPIQ_IDLE) | byte_end);
	// busy slave never takes the buffer
	wire take_s = s_run & tx_full_reg & ~sl_busy_reg;
	wire take_buf = take_m | take_s;
	wire shift_tick = in_shift & tick_end;
	wire [7:0] shift_rot = {shift_reg[6:0], shift_reg[7]};
	// eight rotations return the byte, so it repeats unless rewritten
	wire [7:0] shift_next = !run_en ? `SPIQ_SHIFT_RESET :
		take_buf ? tx_buf_reg :
		shift_tick ? shift_rot : shift_reg;
	wire tx_full_next = data_write |
		(tx_full_reg & ~take_buf);

	// ****************************************
	// master sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		act_next = act_reg;
		mosi_next = mosi_out;
		case (state_reg)
			SPIQ_IDLE: begin
				// a wrap in the load cycle starts at once, within one bit
				if (take_m && tick_end) begin
					state_next = SPIQ_SHIFT;
					bit_next = 3'h0;
					mosi_next = tx_buf_reg[7];
					act_next = clock_phase;
				end else if (take_m)
					state_next = SPIQ_ARMED;
			end
			SPIQ_ARMED: begin
				// start waits for the free-running bit boundary only
				if (tick_end) begin
					state_next = SPIQ_SHIFT;
					bit_next = 3'h0;
					mosi_next = shift_reg[7];
					act_next = clock_phase;
				end
			end
			SPIQ_SHIFT: begin
				if (tick_mid) begin
					act_next = ~clock_phase;
				end else if (tick_end && last_bit && tx_full_reg) begin
					bit_next = 3'h0;
					mosi_next = tx_buf_reg[7];
					act_next = clock_phase;
				end else if (tick_end && last_bit) begin
					state_next = SPIQ_IDLE;
					act_next = 1'b0;
				end else if (tick_end) begin
					bit_next = bit_reg + 3'h1;
					mosi_next = shift_rot[7];
					act_next = clock_phase;
				end
			end
			default: begin
				state_next = SPIQ_IDLE;
				act_next = 1'b0;
			end
		endcase
		if (!m_run) begin
			state_next = SPIQ_IDLE;
			act_next = 1'b0;
		end
	end

	// ****************************************
	// receive path
	// ****************************************
	// miso arrives two flops late, so its capture strobe is delayed too
	wire cap_now = cap_reg[`SPIQ_CAP_DELAY - 1];
	wire m_bit1 = cap_now & (mrx_cnt_reg == `SPIQ_BIT1_CAPTURE);
	wire m_done = cap_now & (mrx_cnt_reg == `SPIQ_LAST_BIT);
	wire start_ev = s_run & (start_s ^ start_q_reg);
	wire s_bit1 = s_run & (bit1_s ^ bit1_q_reg);
	wire s_done = s_run & (done_s ^ done_q_reg);
	wire bit1_hit = master_select ? m_bit1 : s_bit1;
	wire done_hit = master_select ? m_done : s_done;
	wire [7:0] new_byte = master_select ? {mrx_reg, miso_s} : sl_rx;

	wire ovf_set = bit1_hit & rx_full_flag;
	wire ovf_clr = data_read & ovf_arm_reg;
	wire ovf_next = ovf_set | (overflow_flag & ~ovf_clr);
	wire deliver = done_hit & ~ovf_next;
	wire rxf_clr = data_read & rxf_arm_reg;
	wire rxf_next = deliver | (rx_full_flag & ~rxf_clr);

	// ****************************************
	// mode fault
	// ****************************************
	// the system keeps a master's select high; low here is a fault
	wire mode_fault_flag_m = spi_enable & master_select & ~ss_s;
	wire mode_fault_flag_s = s_run & sl_busy_reg & ss_s;
	wire mode_fault_flag_cond = mode_fault_enable & (mode_fault_flag_m | mode_fault_flag_s);
	wire mode_fault_flag_clr = control_write & mode_fault_flag_arm_reg & ~mode_fault_flag_cond;
	wire mode_fault_flag_next = mode_fault_flag_cond |
		(mode_fault_flag & ~mode_fault_flag_clr);
	wire sl_busy_next = s_run & ~ss_s &
		(start_ev | (sl_busy_reg & ~s_done));
	// one request shared by receive full and both error sources
	wire irq_next = (rx_irq_enable & rxf_next) |
		(error_irq_enable & (ovf_next | mode_fault_flag_next));

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= SPIQ_IDLE;
			div_reg <= 7'h00;
			bit_reg <= 3'h0;
			act_reg <= 1'b0;
			shift_reg <= `SPIQ_SHIFT_RESET;
			tx_buf_reg <= `SPIQ_SHIFT_RESET;
			tx_full_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			div_reg <= div_next;
			bit_reg <= bit_next;
			act_reg <= act_next;
			shift_reg <= shift_next;
			if (data_write)
				tx_buf_reg <= write_data;
			tx_full_reg <= tx_full_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cap_reg <= 2'h0;
			mrx_reg <= 7'h00;
			mrx_cnt_reg <= 3'h0;
			start_q_reg <= 1'b0;
			bit1_q_reg <= 1'b0;
			done_q_reg <= 1'b0;
			sl_busy_reg <= 1'b0;
			slave_on_reg <= 1'b0;
			mf_lock_reg <= 1'b0;
		end else begin
			cap_reg <= {cap_reg[0], in_shift & tick_mid};
			if (!m_run)
				mrx_cnt_reg <= 3'h0;
			else if (cap_now)
				mrx_cnt_reg <= mrx_cnt_reg + 3'h1;
			if (cap_now)
				mrx_reg <= {mrx_reg[5:0], miso_s};
			start_q_reg <= start_s;
			bit1_q_reg <= bit1_s;
			done_q_reg <= done_s;
			sl_busy_reg <= sl_busy_next;
			slave_on_reg <= s_run;
			mf_lock_reg <= spi_enable & (mf_lock_reg |
				(mode_fault_enable & mode_fault_flag_m));
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rxf_arm_reg <= 1'b0;
			ovf_arm_reg <= 1'b0;
			mode_fault_flag_arm_reg <= 1'b0;
			rx_full_flag <= 1'b0;
			overflow_flag <= 1'b0;
			mode_fault_flag <= 1'b0;
			rx_data <= `SPIQ_SHIFT_RESET;
			rx_err_irq <= 1'b0;
		end else begin
			rxf_arm_reg <= (status_read & rx_full_flag) |
				(rxf_arm_reg & ~data_read);
			ovf_arm_reg <= (status_read & overflow_flag) |
				(ovf_arm_reg & ~data_read);
			mode_fault_flag_arm_reg <= (status_read & mode_fault_flag) |
				(mode_fault_flag_arm_reg & ~control_write);
			rx_full_flag <= rxf_next;
			overflow_flag <= ovf_next;
			mode_fault_flag <= mode_fault_flag_next;
			if (deliver)
				rx_data <= new_byte;
			rx_err_irq <= irq_next;
		end
	end

	// ****************************************
	// pin drivers, all from flops
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			sck_out <= 1'b0;
			sck_oe_n <= 1'b1;
			mosi_out <= 1'b0;
			mosi_oe_n <= 1'b1;
			tx_empty_flag <= 1'b1;
		end else begin
			sck_out <= clock_polarity ^ act_next;
			sck_oe_n <= ~m_run;
			mosi_out <= mosi_next;
			mosi_oe_n <= ~m_run;
			tx_empty_flag <= ~tx_full_next;
		end
	end
endmodule : spiq_top

// ### test/spiq_top_monitor.sv
// Purpose: port checker for the queued spi block
// Assumes: one mclk domain, rst synchronous and active high
// Notes: the link side is judged only through its effects at the top
module spiq_top_monitor
	import spiq_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic spi_enable,
	input wire logic master_select,
	input wire logic mode_fault_enable,
	input wire logic error_irq_enable,
	input wire logic rx_irq_enable,
	input wire logic data_write,
	input wire logic ss_n_in,
	input wire logic sck_oe_n,
	input wire logic miso_oe_n,
	input wire logic tx_empty_flag,
	input wire logic rx_full_flag,
	input wire logic overflow_flag,
	input wire logic mode_fault_flag,
	input wire spiq_pkg::spiq_byte_t rx_data,
	input wire logic rx_err_irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ****************************************
	// assertions
	// ****************************************
	empty_clear_a: assert property (data_write |=> !tx_empty_flag)
		else $error("empty flag survived a data write");
	master_drive_a: assert property (!sck_oe_n |->
		$past(spi_enable) && $past(master_select))
		else $error("clock driven outside enabled master mode");
	slave_drive_a: assert property (!miso_oe_n |-> !ss_n_in)
		else $error("miso driven while deselected");
	rx_hold_a: assert property (overflow_flag |=> $stable(rx_data))
		else $error("receive data changed during overflow");
	full_hold_a: assert property (overflow_flag |=> !$rose(rx_full_flag))
		else $error("full flag rose during overflow");
	ovf_cause_a: assert property ($rose(overflow_flag) |->
		$past(rx_full_flag))
		else $error("overflow without unread data");
	err_irq_a: assert property ((overflow_flag && error_irq_enable)[*2]
		|-> rx_err_irq)
		else $error("overflow did not raise the request");
	irq_quiet_a: assert property ((!rx_irq_enable && !error_irq_enable)[*2]
		|-> !rx_err_irq)
		else $error("request raised with sources disabled");
	fault_block_a: assert property ((!mode_fault_enable)[*4]
		##0 !mode_fault_flag |=> !mode_fault_flag)
		else $error("fault flag set while disabled");
	fault_set_a: assert property ((spi_enable && master_select &&
		mode_fault_enable && !ss_n_in)[*5] |-> mode_fault_flag)
		else $error("selected master missed the fault");
endmodule : spiq_top_monitor

bind spiq_top spiq_top_monitor mon (.mclk, .rst, .spi_enable, .master_select,
	.mode_fault_enable, .error_irq_enable, .rx_irq_enable, .data_write,
	.ss_n_in, .sck_oe_n, .miso_oe_n, .tx_empty_flag, .rx_full_flag,
	.overflow_flag, .mode_fault_flag, .rx_data, .rx_err_irq);

// ### test/spiq_partner.sv
// Purpose: far end of the serial link, echo slave and link-clock master
// Assumes: phase 1, polarity 0 data exchange
// Notes: released lines show the inverse of their last value
module spiq_partner (
	input wire logic sck_out,
	input wire logic mosi_out,
	input wire logic sck_oe_n,
	input wire logic miso_out,
	input wire logic miso_oe_n,
	output logic miso_in,
	output logic link_sck,
	output logic ss_n_in,
	output logic mosi_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sreg = 8'h00;
	logic miso_reg = 1'b0;
	logic mosi_reg = 1'b0;
	// ****************************************
	// far slave: echoes what it shifted in
	// ****************************************
	initial link_sck = 1'b0;
	initial ss_n_in = 1'b1;
	always @(posedge sck_out) miso_reg = sreg[7];
	always @(negedge sck_out) sreg = {sreg[6:0], mosi_out};
	assign miso_in = sck_oe_n ? ~miso_reg : miso_reg;
	assign mosi_in = ss_n_in ? ~mosi_reg : mosi_reg;
	task load(input logic [7:0] v);
		sreg = v;
	endtask : load
	// ****************************************
	// far master: clock only inside frames
	// ****************************************
	// select stays low afterwards so bytes can follow back to back
	task far_xfer(input logic [7:0] tx, output logic [7:0] rx);
		#13;
		if (ss_n_in) begin
			ss_n_in = 1'b0;
			#400;
		end
		for (int i = 7; i >= 0; i--) begin
			link_sck = 1'b1;
			mosi_reg = tx[i];
			#80;
			link_sck = 1'b0;
			rx[i] = miso_oe_n ? 1'bx : miso_out;
			#80;
		end
	endtask : far_xfer
	task set_select(input logic v);
		#13;
		ss_n_in = v;
	endtask : set_select
endmodule : spiq_partner

// ### test/testbench.sv
// Purpose: self-checking bench of the queued spi block
// Assumes: link clock period 160 ns, bus clock 100 ns
// Notes: bytes are random from a fixed seed
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import spiq_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic spi_enable, master_select, clock_phase, clock_polarity;
	logic mode_fault_enable, error_irq_enable, rx_irq_enable;
	logic data_write, status_read, data_read, control_write;
	spiq_rate_t rate_select;
	spiq_byte_t write_data, rx_data, a, b, x, g;
	logic link_sck, ss_n_in, mosi_in, miso_in, sck_out, sck_oe_n, mosi_out;
	logic mosi_oe_n, miso_out, miso_oe_n, tx_empty_flag, rx_full_flag;
	logic overflow_flag, mode_fault_flag, rx_err_irq, armed, prev_sck;
	int num_errors = 0;
	int check_count = 0;
	int seed = 32'h64a5;
	int cycles = 0;
	int since_wr, since_rise, lat, max_gap;
	spiq_top uut (.mclk, .rst, .link_sck, .spi_enable, .master_select,
		.clock_phase, .clock_polarity, .rate_select, .mode_fault_enable,
		.error_irq_enable, .rx_irq_enable, .data_write, .write_data,
		.status_read, .data_read, .control_write, .ss_n_in, .mosi_in,
		.miso_in, .sck_out, .sck_oe_n, .mosi_out, .mosi_oe_n, .miso_out,
		.miso_oe_n, .tx_empty_flag, .rx_full_flag, .overflow_flag,
		.mode_fault_flag, .rx_data, .rx_err_irq);
	spiq_partner far (.sck_out, .mosi_out, .sck_oe_n, .miso_out, .miso_oe_n,
		.miso_in, .link_sck, .ss_n_in, .mosi_in);
	always #50 mclk = ~mclk;
	// ****************************************
	// watcher: start latency and bit period
	// ****************************************
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles > 20000) begin
			num_errors = num_errors + 1;
			give_verdict();
		end
		prev_sck <= sck_out;
		since_wr <= data_write ? 0 : since_wr + 1;
		since_rise <= since_rise + 1;
		if (data_write)
			armed <= 1'b1;
		else if (armed && sck_out !== prev_sck) begin
			lat <= since_wr;
			armed <= 1'b0;
		end
		if (sck_out === 1'b1 && prev_sck === 1'b0) begin
			since_rise <= 1;
			if (!armed && since_rise > max_gap)
				max_gap <= since_rise;
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	task give_verdict;
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task chk8(input spiq_byte_t got, input spiq_byte_t exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : chk1
	function int bit_len(input logic [1:0] r);
		return 2 << (2 * r);
	endfunction : bit_len
	task tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick
	// kind 0 data write, 1 status read, 2 data read, 3 control write
	task strobe(input int k, input spiq_byte_t v);
		@(posedge mclk);
		data_write <= (k == 0);
		write_data <= v;
		status_read <= (k == 1);
		data_read <= (k == 2);
		control_write <= (k == 3);
		@(posedge mclk);
		{data_write, status_read, data_read, control_write} <= 4'h0;
	endtask : strobe
	task cfg(input logic ms, input logic ph, input logic [1:0] r);
		@(posedge mclk);
		spi_enable <= 1'b0;
		master_select <= ms;
		clock_phase <= ph;
		rate_select <= spiq_rate_t'(r);
		@(posedge mclk);
		spi_enable <= 1'b1;
		tick(4);
	endtask : cfg
	task wait_full;
		for (int n = 0; n < 3000 && rx_full_flag !== 1'b1; n++)
			@(negedge mclk);
		chk1(rx_full_flag, 1'b1);
	endtask : wait_full
	task clear_rx;
		strobe(1, 8'h00);
		strobe(2, 8'h00);
		tick(2);
	endtask : clear_rx
	task mbyte(input logic [1:0] r);
		a = $random(seed);
		b = $random(seed);
		cfg(1'b1, 1'b1, r);
		far.load(b);
		max_gap = 0;
		strobe(0, a);
		tick(1);
		chk1(tx_empty_flag, 1'b0);
		tick(1);
		chk1(tx_empty_flag, 1'b1);
		wait_full;
		chk1(lat <= bit_len(r), 1'b1);
		chk1(mosi_oe_n, 1'b0);
		chk1(max_gap == bit_len(r), 1'b1);
		chk8(rx_data, b);
		chk8(far.sreg, a);
		clear_rx;
		chk1(rx_full_flag, 1'b0);
	endtask : mbyte
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{spi_enable, master_select, clock_phase, clock_polarity} = 4'h0;
		{mode_fault_enable, error_irq_enable, rx_irq_enable} = 3'h0;
		{data_write, status_read, data_read, control_write} = 4'h0;
		{armed, prev_sck} = 2'h0;
		{since_wr, since_rise, lat, max_gap} = 128'h0;
		rate_select = SPIQ_DIV2;
		write_data = 8'h00;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		for (int r = 0; r < 4; r++)
			mbyte(r[1:0]);
		// queued byte follows the first with no stretched bit
		a = $random(seed);
		cfg(1'b1, 1'b1, 2'h1);
		far.load(8'h5a);
		max_gap = 0;
		strobe(0, a);
		tick(3);
		strobe(0, $random(seed));
		wait_full;
		chk8(rx_data, 8'h5a);
		clear_rx;
		wait_full;
		chk8(rx_data, a);
		chk1(max_gap == 8, 1'b1);
		clear_rx;
		// slave: buffer held during a frame, then overflow
		a = $random(seed);
		b = $random(seed);
		cfg(1'b0, 1'b1, 2'h0);
		@(posedge mclk) error_irq_enable <= 1'b1;
		strobe(0, a);
		tick(6);
		fork
			far.far_xfer(8'hc3, g);
			begin
				tick(8);
				strobe(0, b);
				tick(2);
				chk1(tx_empty_flag, 1'b0);
			end
		join
		tick(8);
		chk1(tx_empty_flag, 1'b1);
		chk8(g, a);
		wait_full;
		chk8(rx_data, 8'hc3);
		for (int k = 0; k < 2; k++) begin
			far.far_xfer($random(seed), g);
			tick(8);
			chk8(g, b);
			chk1(overflow_flag, 1'b1);
			chk8(rx_data, 8'hc3);
			chk1(rx_err_irq, 1'b1);
		end
		strobe(2, 8'h00);
		tick(2);
		chk1(overflow_flag, 1'b1);
		clear_rx;
		chk1(overflow_flag, 1'b0);
		chk1(rx_full_flag, 1'b0);
		x = $random(seed);
		far.far_xfer(x, g);
		tick(8);
		chk8(rx_data, x);
		far.set_select(1'b1);
		tick(2);
		chk1(miso_oe_n, 1'b1);
		clear_rx;
		// phase 0: clock stays inactive for the first half bit
		cfg(1'b1, 1'b0, 2'h1);
		strobe(0, $random(seed));
		wait_full;
		chk1(lat >= 4, 1'b1);
		clear_rx;
		// master select pulled low: fault only when enabled
		far.set_select(1'b0);
		tick(8);
		chk1(mode_fault_flag, 1'b0);
		@(posedge mclk) mode_fault_enable <= 1'b1;
		tick(8);
		chk1(mode_fault_flag, 1'b1);
		chk1(rx_err_irq, 1'b1);
		chk1(mosi_oe_n, 1'b1);
		far.set_select(1'b1);
		tick(4);
		strobe(1, 8'h00);
		strobe(3, 8'h00);
		tick(2);
		chk1(mode_fault_flag, 1'b0);
		give_verdict();
	end
endmodule : testbench
